//--- core/iolp_pkg.sv
// Shared constants and carrier types for the I/O expander with LED PWM.
// Assumes a 20 MHz system clock and a free-standing PWM oscillator clock.
`default_nettype none

package iolp_pkg;

  // ************************************************************
  // Register map, one byte per index, reached over the serial link
  // ************************************************************
  localparam int         NREG          = 21;
  localparam logic [4:0] REG_IN_LO     = 5'h00;
  localparam logic [4:0] REG_IN_HI     = 5'h01;
  localparam logic [4:0] REG_PH0_LO    = 5'h02;
  localparam logic [4:0] REG_PH1_LO    = 5'h04;
  localparam logic [4:0] REG_DIR_LO    = 5'h06;
  localparam logic [4:0] REG_PWMEN_LO  = 5'h08;
  localparam logic [4:0] REG_MASTER    = 5'h0a;
  localparam logic [4:0] REG_CFG       = 5'h0b;
  localparam logic [4:0] REG_INDIV0    = 5'h0c;
  localparam logic [4:0] REG_GLOBAL    = 5'h14;
  localparam logic [4:0] REG_LAST      = 5'h14;

  // Configuration register fields
  localparam int         CFG_BLINK_EN  = 0;
  localparam int         CFG_FLIP      = 1;
  localparam int         CFG_IRQ_EN    = 2;
  localparam int         CFG_GLOBAL    = 3;
  localparam int         CFG_O16_PH0   = 4;
  localparam int         CFG_O16_PH1   = 5;

  // Reset values
  localparam logic [7:0] DIR_RST       = 8'hff;
  localparam logic [7:0] PH_RST        = 8'hff;
  localparam logic [7:0] CFG_RST       = 8'h34;
  localparam logic [7:0] OTHER_RST     = 8'h00;

  // PWM frame: 15 master windows of 16 individual steps each
  localparam int         PWM_OSC_HZ    = 32000;
  localparam logic [7:0] PWM_STEPS     = 8'hf0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    AD_GND = 2'b00,
    AD_VCC = 2'b01,
    AD_SCL = 2'b10,
    AD_SDA = 2'b11
  } iolp_adpin_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WR   = 3'b011,
    ST_WACK = 3'b100,
    ST_RD   = 3'b101,
    ST_RACK = 3'b110,
    ST_SKIP = 3'b111
  } iolp_i2c_e;

  typedef struct packed {
    logic [15:0]      en;
    logic [15:0][7:0] thr;
  } iolp_pwm_cfg_s;

  function automatic logic [7:0] reg_reset(input int idx);
    if (idx >= int'(REG_PH0_LO) && idx < int'(REG_DIR_LO))
      return PH_RST;
    if (idx == int'(REG_DIR_LO) || idx == int'(REG_DIR_LO) + 1)
      return DIR_RST;
    if (idx == int'(REG_CFG))
      return CFG_RST;
    return OTHER_RST;
  endfunction

endpackage

`default_nettype wire

//--- core/iolp_sync2.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a level that may be sampled bit by bit.
`timescale 1ns/1ps
`default_nettype none

module iolp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } iolp_sync_st_s;

  iolp_sync_st_s st_ff;
  iolp_sync_st_s nxt_st;

  // First stage feeds only the second stage
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.meta = d_i;
    nxt_st.q    = st_ff.meta;
  end

  always_ff @(posedge clk_i)
  begin
    st_ff <= nxt_st;
  end

  assign q_o = st_ff.q;

endmodule

`default_nettype wire

//--- core/iolp_pwm.sv
// PWM frame counter running on the internal oscillator clock.
// Assumes cfg_i holds still while req_tog_i differs from ack_tog_o.
`timescale 1ns/1ps
`default_nettype none

module iolp_pwm (
  input  wire logic                    clk_pwm_i,
  input  wire logic                    rst_n_i,
  input  wire iolp_pkg::iolp_pwm_cfg_s cfg_i,
  input  wire logic                    req_tog_i,
  output logic                         ack_tog_o,
  output logic [15:0]                  on_o
);

  typedef struct packed {
    iolp_pkg::iolp_pwm_cfg_s cfg;
    logic                    ack;
    logic [7:0]              cnt;
    logic [15:0]             on;
  } iolp_pwm_st_s;

  iolp_pwm_st_s st_ff;
  iolp_pwm_st_s nxt_st;
  logic         rst_n_s;
  logic         tog_s;

  // Reset and request toggle brought into the oscillator domain
  iolp_sync2 #(.W(2)) u_sync (
    .clk_i (clk_pwm_i),
    .d_i   ({rst_n_i, req_tog_i}),
    .q_o   ({rst_n_s, tog_s})
  );

  // Frame counter idles at zero while no output uses PWM
  always_comb
  begin
    nxt_st = st_ff;
    if (!rst_n_s)
    begin
      nxt_st = '0;
    end
    else
    begin
      if (tog_s != st_ff.ack)
      begin
        nxt_st.cfg = cfg_i;
        nxt_st.ack = tog_s;
      end
      if (st_ff.cfg.en == 16'h0000 || st_ff.cnt == iolp_pkg::PWM_STEPS - 8'h01)
        nxt_st.cnt = 8'h00;
      else
        nxt_st.cnt = st_ff.cnt + 8'h01;
      for (int i = 0; i < 16; i++)
        nxt_st.on[i] = st_ff.cfg.en[i] && (st_ff.cnt < st_ff.cfg.thr[i]);
    end
  end

  always_ff @(posedge clk_pwm_i)
  begin
    st_ff <= nxt_st;
  end

  assign ack_tog_o = st_ff.ack;
  assign on_o      = st_ff.on;

endmodule

`default_nettype wire

//--- core/iolp_top.sv
// Sixteen-port open-drain expander with a serial slave, blink and PWM dimming.
// Assumes the pins arrive asynchronously and the PWM clock is unrelated.
//
// Overview of operation
// - ports come up as inputs, not sinking
// - input registers show live pin levels
// - reading input register latches its eight-port sample
// - sample mismatch on inputs pulls interrupt low
// - interrupt releases on return or register read
// - seventeenth pin is interrupt or blinkable output
// - blink off: phase-zero registers drive outputs
// - blink on: flip flag picks phase register
// - PWM timing comes from on-chip oscillator
// - PWM per output; others static, glitch free
// - no PWM anywhere stops the oscillator
// - master nibble limits pulse to n/15
// - individual nibble scales window in sixteenths
// - global mode: one byte, 240 steps
// - standby when bus idle and PWM unused
// - start, address, command, data, stop
// - data changes only while clock low
// - receiver acknowledges each byte on ninth clock
// - direction bit low writes, high reads
// - three four-way address pins give 64 addresses
// - command byte alone just sets the pointer
// - written bytes go to successive registers
// - reads use pointer and advance it
`timescale 1ns/1ps
`default_nettype none

module iolp_top (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_pwm_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        addr_sel_pin_zero_i,
  input  wire logic        addr_sel_pin_one_i,
  input  wire logic        addr_sel_pin_two_i,
  input  wire logic [15:0] port_pins_i,
  output logic      [15:0] port_pins_o,
  output logic      [15:0] port_pins_oe_o,
  output logic             irq_or_out_seventeen_o,
  output logic             irq_or_out_seventeen_oe_o,
  output logic             osc_run_o,
  output logic             standby_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [iolp_pkg::NREG-1:0][7:0] regs;
    logic [15:0]                    sample;
    logic [4:0]                     ptr;
    iolp_pkg::iolp_i2c_e            fsm;
    logic [2:0]                     bitn;
    logic                           full;
    logic [7:0]                     shreg;
    logic                           rw;
    logic                           cmd_phase;
    logic                           mack;
    logic                           scl_raw;
    logic                           sda_raw;
    logic                           scl_f;
    logic                           sda_f;
    logic                           scl_fd;
    logic                           sda_fd;
    logic [2:0][3:0]                ad_mis;
    logic                           sda_oe;
    logic [15:0]                    pin_oe;
    logic                           irq_oe;
    logic                           osc_run;
    logic                           standby;
    logic [16:0]                    drv_lo;
    iolp_pkg::iolp_pwm_cfg_s        snap;
    logic                           req_tog;
  } iolp_top_st_s;

  iolp_top_st_s            st_ff;
  iolp_top_st_s            nxt_st;
  logic [15:0]             pins_s;
  logic                    scl_s;
  logic                    sda_s;
  logic [2:0]              ad_s;
  logic [15:0]             pwm_on_s;
  logic                    ack_s;
  logic                    pwm_ack;
  logic [15:0]             pwm_on;
  iolp_pkg::iolp_pwm_cfg_s pwm_want;

  // ************************************************************
  // Helpers
  // ************************************************************

  // Pointer walks the map and wraps after the last register
  function automatic logic [4:0] ptr_inc(input logic [4:0] p);
    return (p == iolp_pkg::REG_LAST) ? 5'h00 : p + 5'h01;
  endfunction

  // Strap class from the first line the pin has never failed to follow
  function automatic logic [1:0] ad_class(input logic [3:0] mis);
    if (!mis[0])
      return iolp_pkg::AD_GND;
    if (!mis[1])
      return iolp_pkg::AD_VCC;
    if (!mis[2])
      return iolp_pkg::AD_SCL;
    return iolp_pkg::AD_SDA;
  endfunction

  // Seven-bit address: high code bit marks a bus-line strap
  function automatic logic [6:0] addr_of(input logic [1:0] c2, input logic [1:0] c1,
                                         input logic [1:0] c0);
    return {c2[1], ~c1[1], c1[1], c0[1], c2[0], c1[0], c0[0]};
  endfunction

  // On-time in PWM ticks out of a 240-tick frame
  function automatic logic [7:0] pwm_thr(input logic [3:0] master, input logic [3:0] indiv,
                                         input logic glob_mode, input logic [7:0] glob);
    logic [7:0] prod;
    prod = {4'h0, master} * {4'h0, indiv};
    return glob_mode ? glob : prod;
  endfunction

  // ************************************************************
  // Pin capture and clock crossing
  // ************************************************************
  iolp_sync2 #(.W(21)) u_pin_sync (
    .clk_i (clk_sys_i),
    .d_i   ({port_pins_i, scl_i, sda_i, addr_sel_pin_two_i, addr_sel_pin_one_i, addr_sel_pin_zero_i}),
    .q_o   ({pins_s, scl_s, sda_s, ad_s})
  );

  iolp_sync2 #(.W(17)) u_pwm_sync (
    .clk_i (clk_sys_i),
    .d_i   ({pwm_on, pwm_ack}),
    .q_o   ({pwm_on_s, ack_s})
  );

  iolp_pwm u_pwm (
    .clk_pwm_i (clk_pwm_i),
    .rst_n_i   (rst_n_i),
    .cfg_i     (st_ff.snap),
    .req_tog_i (st_ff.req_tog),
    .ack_tog_o (pwm_ack),
    .on_o      (pwm_on)
  );

  // Wanted PWM setting from the intensity registers
  always_comb
  begin
    pwm_want.en = {st_ff.regs[iolp_pkg::REG_PWMEN_LO + 5'h01], st_ff.regs[iolp_pkg::REG_PWMEN_LO]};
    for (int i = 0; i < 16; i++)
      pwm_want.thr[i] = pwm_thr(st_ff.regs[iolp_pkg::REG_MASTER][3:0],
                                st_ff.regs[int'(iolp_pkg::REG_INDIV0) + i / 2][(i % 2) * 4 +: 4],
                                st_ff.regs[iolp_pkg::REG_CFG][iolp_pkg::CFG_GLOBAL],
                                st_ff.regs[iolp_pkg::REG_GLOBAL]);
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;
    logic [15:0] dir;
    logic [15:0] lvl;
    logic        blink;
    logic        o16_lvl;
    logic [7:0]  rdat;
    nxt_st  = st_ff;
    rise    = st_ff.scl_f & ~st_ff.scl_fd;
    fall    = ~st_ff.scl_f & st_ff.scl_fd;
    start   = st_ff.scl_f & st_ff.scl_fd & st_ff.sda_fd & ~st_ff.sda_f;
    stop    = st_ff.scl_f & st_ff.scl_fd & ~st_ff.sda_fd & st_ff.sda_f;
    rdat    = st_ff.regs[st_ff.ptr];
    dir   = {st_ff.regs[iolp_pkg::REG_DIR_LO + 5'h01], st_ff.regs[iolp_pkg::REG_DIR_LO]};
    blink = st_ff.regs[iolp_pkg::REG_CFG][iolp_pkg::CFG_BLINK_EN] & st_ff.regs[iolp_pkg::REG_CFG][iolp_pkg::CFG_FLIP];
    lvl   = blink ? {st_ff.regs[iolp_pkg::REG_PH1_LO + 5'h01], st_ff.regs[iolp_pkg::REG_PH1_LO]}
                  : {st_ff.regs[iolp_pkg::REG_PH0_LO + 5'h01], st_ff.regs[iolp_pkg::REG_PH0_LO]};
    o16_lvl = blink ? st_ff.regs[iolp_pkg::REG_CFG][iolp_pkg::CFG_O16_PH1]
                    : st_ff.regs[iolp_pkg::REG_CFG][iolp_pkg::CFG_O16_PH0];

    // Spike filter: a line level is accepted after two equal samples
    nxt_st.scl_raw = scl_s;
    nxt_st.sda_raw = sda_s;
    if (scl_s == st_ff.scl_raw)
      nxt_st.scl_f = scl_s;
    if (sda_s == st_ff.sda_raw)
      nxt_st.sda_f = sda_s;
    nxt_st.scl_fd = st_ff.scl_f;
    nxt_st.sda_fd = st_ff.sda_f;

    // Strap learning: a pin is ruled out of each class it contradicts
    for (int p = 0; p < 3; p++)
    begin
      nxt_st.ad_mis[p][0] = st_ff.ad_mis[p][0] | ad_s[p];
      nxt_st.ad_mis[p][1] = st_ff.ad_mis[p][1] | ~ad_s[p];
      nxt_st.ad_mis[p][2] = st_ff.ad_mis[p][2] | (ad_s[p] ^ scl_s);
      nxt_st.ad_mis[p][3] = st_ff.ad_mis[p][3] | (ad_s[p] ^ sda_s);
    end

    // Bit counter: eight rising clock edges make a byte
    if (rise && (st_ff.fsm == iolp_pkg::ST_ADDR || st_ff.fsm == iolp_pkg::ST_WR || st_ff.fsm == iolp_pkg::ST_RD))
    begin
      if (st_ff.fsm != iolp_pkg::ST_RD)
        nxt_st.shreg = {st_ff.shreg[6:0], st_ff.sda_f};
      nxt_st.bitn = st_ff.bitn + 3'h1;
      nxt_st.full = (st_ff.bitn == 3'h7);
    end

    // Slave sequencer; all drive changes happen on falling clock edges
    unique case (st_ff.fsm)
      iolp_pkg::ST_IDLE,
      iolp_pkg::ST_SKIP:
      begin
        nxt_st.sda_oe = 1'b0;
      end
      iolp_pkg::ST_ADDR:
      begin
        if (fall && st_ff.full)
        begin
          nxt_st.full = 1'b0;
          if (st_ff.shreg[7:1] == addr_of(ad_class(st_ff.ad_mis[2]), ad_class(st_ff.ad_mis[1]),
                                          ad_class(st_ff.ad_mis[0])))
          begin
            nxt_st.sda_oe = 1'b1;
            nxt_st.rw     = st_ff.shreg[0];
            nxt_st.fsm    = iolp_pkg::ST_AACK;
          end
          else
            nxt_st.fsm = iolp_pkg::ST_SKIP;
        end
      end
      iolp_pkg::ST_AACK:
      begin
        if (fall)
        begin
          nxt_st.bitn = 3'h0;
          if (st_ff.rw)
          begin
            nxt_st.shreg  = rdat;
            nxt_st.sda_oe = ~rdat[7];
            nxt_st.ptr    = ptr_inc(st_ff.ptr);
            if (st_ff.ptr == iolp_pkg::REG_IN_LO)
              nxt_st.sample[7:0] = pins_s[7:0];
            if (st_ff.ptr == iolp_pkg::REG_IN_HI)
              nxt_st.sample[15:8] = pins_s[15:8];
            nxt_st.fsm = iolp_pkg::ST_RD;
          end
          else
          begin
            nxt_st.sda_oe    = 1'b0;
            nxt_st.cmd_phase = 1'b1;
            nxt_st.fsm       = iolp_pkg::ST_WR;
          end
        end
      end
      iolp_pkg::ST_WR:
      begin
        if (fall && st_ff.full)
        begin
          nxt_st.full   = 1'b0;
          nxt_st.sda_oe = 1'b1;
          nxt_st.fsm    = iolp_pkg::ST_WACK;
          if (st_ff.cmd_phase)
          begin
            nxt_st.cmd_phase = 1'b0;
            nxt_st.ptr = (st_ff.shreg <= {3'h0, iolp_pkg::REG_LAST}) ? st_ff.shreg[4:0] : 5'h00;
          end
          else
          begin
            if (st_ff.ptr > iolp_pkg::REG_IN_HI)
              nxt_st.regs[st_ff.ptr] = st_ff.shreg;
            nxt_st.ptr = ptr_inc(st_ff.ptr);
          end
        end
      end
      iolp_pkg::ST_WACK:
      begin
        if (fall)
        begin
          nxt_st.sda_oe = 1'b0;
          nxt_st.bitn   = 3'h0;
          nxt_st.fsm    = iolp_pkg::ST_WR;
        end
      end
      iolp_pkg::ST_RD:
      begin
        if (fall && st_ff.full)
        begin
          nxt_st.full   = 1'b0;
          nxt_st.sda_oe = 1'b0;
          nxt_st.fsm    = iolp_pkg::ST_RACK;
        end
        else if (fall)
        begin
          nxt_st.shreg  = {st_ff.shreg[6:0], 1'b0};
          nxt_st.sda_oe = ~st_ff.shreg[6];
        end
      end
      iolp_pkg::ST_RACK:
      begin
        if (rise)
          nxt_st.mack = ~st_ff.sda_f;
        if (fall)
        begin
          nxt_st.bitn = 3'h0;
          if (st_ff.mack)
          begin
            nxt_st.shreg  = rdat;
            nxt_st.sda_oe = ~rdat[7];
            nxt_st.ptr    = ptr_inc(st_ff.ptr);
            if (st_ff.ptr == iolp_pkg::REG_IN_LO)
              nxt_st.sample[7:0] = pins_s[7:0];
            if (st_ff.ptr == iolp_pkg::REG_IN_HI)
              nxt_st.sample[15:8] = pins_s[15:8];
            nxt_st.fsm = iolp_pkg::ST_RD;
          end
          else
            nxt_st.fsm = iolp_pkg::ST_SKIP;
        end
      end
    endcase

    // Start and stop override any byte in progress, including repeated start
    if (start)
    begin
      nxt_st.fsm    = iolp_pkg::ST_ADDR;
      nxt_st.bitn   = 3'h0;
      nxt_st.full   = 1'b0;
      nxt_st.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      nxt_st.fsm    = iolp_pkg::ST_IDLE;
      nxt_st.sda_oe = 1'b0;
    end

    // Input registers always mirror the live pins, outputs included
    nxt_st.regs[iolp_pkg::REG_IN_LO] = pins_s[7:0];
    nxt_st.regs[iolp_pkg::REG_IN_HI] = pins_s[15:8];

    // Port drive: outputs registered so a static pin never glitches
    for (int i = 0; i < 16; i++)
      nxt_st.pin_oe[i] = ~dir[i] & ~lvl[i] & (~st_ff.snap.en[i] | pwm_on_s[i]);

    // Seventeenth pin: interrupt from the sample compare, or a plain output
    if (st_ff.regs[iolp_pkg::REG_CFG][iolp_pkg::CFG_IRQ_EN])
      nxt_st.irq_oe = |((pins_s ^ st_ff.sample) & dir);
    else
      nxt_st.irq_oe = ~o16_lvl;

    // PWM setting handed over only when the previous hand-over is done
    if (st_ff.req_tog == ack_s && pwm_want != st_ff.snap)
    begin
      nxt_st.snap    = pwm_want;
      nxt_st.req_tog = ~st_ff.req_tog;
    end

    // Oscillator runs only while some output uses PWM
    nxt_st.osc_run = |pwm_want.en;
    nxt_st.standby = (nxt_st.fsm == iolp_pkg::ST_IDLE) & ~(|pwm_want.en);
    nxt_st.drv_lo  = 17'h00000;

    // Reset last so it overrides all of the above
    if (!rst_n_i)
    begin
      nxt_st = '0;
      for (int r = 0; r < iolp_pkg::NREG; r++)
        nxt_st.regs[r] = iolp_pkg::reg_reset(r);
      nxt_st.scl_raw = 1'b1;
      nxt_st.sda_raw = 1'b1;
      nxt_st.scl_f   = 1'b1;
      nxt_st.sda_f   = 1'b1;
      nxt_st.scl_fd  = 1'b1;
      nxt_st.sda_fd  = 1'b1;
      nxt_st.standby = 1'b1;
      nxt_st.sample  = pins_s; // Avoids a false interrupt when reset ends
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    st_ff <= nxt_st;
  end

  // ************************************************************
  // Outputs, all straight from flops; SCL is never driven
  // ************************************************************
  assign sda_o                     = st_ff.drv_lo[16];
  assign sda_oe_o                  = st_ff.sda_oe;
  assign port_pins_o               = st_ff.drv_lo[15:0];
  assign port_pins_oe_o            = st_ff.pin_oe;
  assign irq_or_out_seventeen_o    = st_ff.drv_lo[16];
  assign irq_or_out_seventeen_oe_o = st_ff.irq_oe;
  assign osc_run_o                 = st_ff.osc_run;
  assign standby_o                 = st_ff.standby;

endmodule

`default_nettype wire

//--- dv/iolp_monitor.sv
// Port checker for the expander top.
// Assumes one system clock domain; bound into every top instance.
`timescale 1ns/1ps
`default_nettype none
module iolp_monitor (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic [15:0] port_pins_o,
  input wire logic [15:0] port_pins_oe_o,
  input wire logic        irq_or_out_seventeen_o,
  input wire logic        osc_run_o,
  input wire logic        standby_o
);
  // Sync reset: state is seen one edge after reset is sampled
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_reset_all_quiet: assert property (disable iff (1'b0) !rst_n_i |=> !port_pins_oe_o && !sda_oe_o && standby_o && !osc_run_o)
    else $error("outputs active after reset");
  a_pins_open_drain: assert property (!sda_o && !port_pins_o && !irq_or_out_seventeen_o)
    else $error("pin data not held low");
  a_sda_edge_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data moved with clock high");
  a_ack_stands: assert property ($rose(sda_oe_o) |=> sda_oe_o [*8])
    else $error("data drive too short");
  a_standby_excl: assert property (standby_o |-> !osc_run_o)
    else $error("standby with oscillator on");
  a_static_moves: assert property (!osc_run_o && $changed(port_pins_oe_o) |-> !scl_i)
    else $error("static output moved outside write");
  a_standby_wake: assert property ($fell(standby_o) |-> !sda_i || !scl_i || osc_run_o)
    else $error("standby left without cause");
  a_standby_rise: assert property ($rose(standby_o) |-> scl_i && !osc_run_o)
    else $error("standby entered while busy");
endmodule
bind iolp_top iolp_monitor mon_u (.clk_sys_i, .rst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .port_pins_o,
  .port_pins_oe_o, .irq_or_out_seventeen_o, .osc_run_o, .standby_o);
`default_nettype wire

//--- dv/iolp_i2c_master.sv
// Serial bus master model: makes the clock, frames and bits.
// Assumes an open-drain data line with pull-up wired by the bench.
`timescale 1ns/1ps
`default_nettype none
module iolp_i2c_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // Clock parks high between frames
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Data falls with clock high; serves as repeated start too
  task automatic start();
    sda_o = 1'b1;
    w(4);
    scl_o = 1'b1;
    w(14);
    sda_o = 1'b0;
    w(14);
    scl_o = 1'b0;
  endtask
  // Long hold after the fall covers the slave's sync delay
  task automatic bit_x(input logic b, output logic s);
    w(10);
    sda_o = b;
    w(20);
    scl_o = 1'b1;
    w(10);
    s = sda_i;
    w(10);
    scl_o = 1'b0;
  endtask
  // Eight bits msb first, then the ninth clock
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
    for (int j = 7; j >= 0; j--)
      bit_x(d[j], q[j]);
    bit_x(a, ak);
  endtask
  task automatic stop();
    w(10);
    sda_o = 1'b0;
    w(20);
    scl_o = 1'b1;
    w(14);
    sda_o = 1'b1;
    w(30);
  endtask
endmodule
`default_nettype wire

//--- dv/iolp_top_tb.sv
// Bench for the expander: writes, reads, blink, interrupt, PWM duty.
// Assumes straps at ground (address 0x20) and the master model.
`timescale 1ns/1ps
`default_nettype none
module iolp_top_tb;
  logic [7:0]  cfgs [5] = '{8'h11, 8'h23, 8'h13, 8'h21, 8'h12};
  logic        clk, rst_n, clk_pwm, ack;
  logic [15:0] ext, ph0, ph1;
  logic [7:0]  wb [3];
  logic [7:0]  rb [2];
  logic [7:0]  q;
  wire         scl, mst_sda, sda, sda_oe, irq_oe, osc_run, standby;
  wire  [15:0] pins_oe, pins_i;
  int          fail_count, checks, cyc, seed, k;
  // Wired-and lines with pull-ups
  assign sda = mst_sda & ~sda_oe;
  assign pins_i = ext & ~pins_oe;
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    clk_pwm = 0;
    #7;
    forever #24 clk_pwm = ~clk_pwm;
  end
  iolp_i2c_master mst_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(mst_sda));
  iolp_top dut_u (.clk_sys_i(clk), .rst_n_i(rst_n), .clk_pwm_i(clk_pwm), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(sda_oe), .addr_sel_pin_zero_i(1'b0), .addr_sel_pin_one_i(1'b0),
    .addr_sel_pin_two_i(1'b0), .port_pins_i(pins_i), .port_pins_o(), .port_pins_oe_o(pins_oe),
    .irq_or_out_seventeen_o(), .irq_or_out_seventeen_oe_o(irq_oe), .osc_run_o(osc_run), .standby_o(standby));
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input int n);
    mst_u.start();
    mst_u.xfer(8'h40, 1'b1, q, ack);
    chk("waddr ack", 0, ack);
    mst_u.xfer(cmd, 1'b1, q, ack);
    chk("cmd ack", 0, ack);
    for (int j = 0; j < n; j++)
    begin
      mst_u.xfer(wb[j], 1'b1, q, ack);
      chk("data ack", 0, ack);
    end
    mst_u.stop();
  endtask
  // Last byte is refused by the master to end the read
  task automatic rd(input int n);
    mst_u.start();
    mst_u.xfer(8'h41, 1'b1, q, ack);
    chk("raddr ack", 0, ack);
    for (int j = 0; j < n; j++)
      mst_u.xfer(8'hff, j == n - 1, rb[j], ack);
    mst_u.stop();
  endtask
  // Window is exactly ten frames, so phase does not matter
  task automatic duty(input int on);
    int e, c;
    e = on * 96 / 10;
    c = 0;
    w(300);
    repeat (2304)
    begin
      @(negedge clk);
      c += pins_oe[0];
    end
    chk("duty", 1, c <= e + 40 && c + 40 >= e);
  endtask
  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  initial
  begin
    seed = 32'h4e8f;
    rst_n = 0;
    ext = 16'hffff;
    w(12);
    rst_n = 1;
    w(6);
    chk("reset oe", 0, pins_oe);
    chk("reset idle", 16'h1, {osc_run, standby});
    chk("reset irq", 0, irq_oe);
    ph0 = 16'($random(seed));
    ph1 = 16'($random(seed));
    {wb[1], wb[0]} = ph0;
    wr(8'h02, 2);
    {wb[1], wb[0]} = ph1;
    wb[2] = 8'h00;
    wr(8'h04, 3);
    wb[0] = 8'h00;
    wr(8'h07, 1);
    chk("phase0", ~ph0, pins_oe);
    wr(8'h00, 0);
    rd(2);
    chk("levels", ph0, {rb[1], rb[0]});
    foreach (cfgs[j])
    begin
      wb[0] = cfgs[j];
      wr(8'h0b, 1);
      chk("blink", (cfgs[j][0] & cfgs[j][1]) ? ~ph1 : ~ph0, pins_oe);
      chk("pin17", !cfgs[j][(cfgs[j][0] & cfgs[j][1]) ? 5 : 4], irq_oe);
    end
    wb[0] = 8'hff;
    wb[1] = 8'hff;
    wr(8'h06, 2);
    wb[0] = 8'h34;
    wr(8'h0b, 1);
    wr(8'h00, 0);
    rd(2);
    k = $unsigned($random(seed)) % 16;
    ext[k] = 0;
    w(10);
    chk("irq set", 1, irq_oe);
    ext[k] = 1;
    w(10);
    chk("irq back", 0, irq_oe);
    ext[k] = 0;
    w(10);
    wr(8'(k / 8), 0);
    rd(1);
    chk("irq read", 0, irq_oe);
    chk("in byte", 8'hff & ~(8'h01 << (k % 8)), rb[0]);
    ext[k] = 1;
    w(10);
    chk("new ref", 1, irq_oe);
    wb[0] = 8'hfe;
    wr(8'h06, 1);
    wr(8'h02, 1);
    wb[0] = 8'h01;
    wb[1] = 8'h00;
    wb[2] = 8'(1 + $unsigned($random(seed)) % 15);
    wr(8'h08, 3);
    wb[1] = 8'(1 + $unsigned($random(seed)) % 15);
    wb[0] = wb[1];
    wr(8'h0c, 1);
    chk("osc on", 16'h2, {osc_run, standby});
    duty(wb[2] * wb[1]);
    wb[0] = 8'h3c;
    wr(8'h0b, 1);
    wb[0] = 8'(1 + $unsigned($random(seed)) % 239);
    wb[1] = wb[0];
    wr(8'h14, 1);
    duty(wb[1]);
    wb[0] = 8'h00;
    wr(8'h08, 1);
    chk("osc off", 16'h1, {osc_run, standby});
    chk("static", 1, pins_oe[0]);
    wrap_up();
  end
endmodule
`default_nettype wire
